// ### shared/i2c_slave_pkg.sv
// Constants and types shared by the two-wire register access slave.
// Assumes an 8-bit register space reached through index, strobe and data signals.
`default_nettype none

package i2c_slave_pkg;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  // Upper six bits of the slave address, binary 010110
  localparam logic [5:0] SLAVE_ADDR_HIGH = 6'h16;
  localparam logic DIR_READ = 1'b1;
  localparam logic LSB_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Byte framing and register index
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] INDEX_ZERO = 8'h00;
  localparam logic [7:0] INDEX_STEP = 8'h01;
  localparam logic [7:0] INDEX_MAX = 8'hff;
  // Highest implemented register; indices above it do not exist
  localparam logic [7:0] LAST_REG_DEFAULT = 8'h7f;

  // ----------------------------------------------------------------
  // Write buffer and pin synchroniser layout
  // ----------------------------------------------------------------
  localparam int FIFO_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_W = 5;
  localparam int SYN_SCL = 0;
  localparam int SYN_SDA = 1;
  localparam int SYN_RSTN = 2;
  localparam int SYN_STRAP = 3;
  localparam int SYN_LBIT = 4;
  // Idle-high lines start high so no false edge or event follows reset
  localparam logic [4:0] SYNC_INIT = 5'h17;

  // ----------------------------------------------------------------
  // Protocol states
  // ----------------------------------------------------------------
  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_INDEX,
    ST_INDEX_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK,
    ST_IGNORE
  } state_t;

endpackage : i2c_slave_pkg

`default_nettype wire

// ### src/sync_bits.sv
// Two-flop synchroniser, one chain per bit.
// Assumes the inputs are levels that stay put for several clock periods.
`timescale 1ns/1ps
`default_nettype none

module sync_bits #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // System
  input wire logic clock,
  input wire logic sys_rst,
  // Data
  input wire logic [WIDTH-1:0] dataIn,
  output logic [WIDTH-1:0] dataOut
);

  genvar i;
  for (i = 0; i < WIDTH; i++) begin : gBit
    logic stage1;
    logic stage2;
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        stage1 <= INIT[i];
        stage2 <= INIT[i];
      end else begin
        stage1 <= dataIn[i];
        stage2 <= stage1;
      end
    end
    assign dataOut[i] = stage2;
  end

endmodule : sync_bits

`default_nettype wire

// ### src/fifo_buffer.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps
`default_nettype none

module fifo_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // System
  input wire logic clock,
  input wire logic sys_rst,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign inReady = (count != FULL_COUNT);
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  chk_fifo_bound: assert property (@(posedge clock) disable iff (sys_rst)
    (count == FULL_COUNT) && !pop |=> (count == FULL_COUNT))
    else $error("fifo count left full without a pop");

endmodule : fifo_buffer

`default_nettype wire

// ### src/i2c_register_access_slave.sv
// Two-wire serial slave giving a bus master access to 8-bit registers.
// Assumes a register file that takes write strobes and returns read data
// combinationally for the index it is shown.
//
// Function
// - Answer only address 010110 plus strap bit
// - Reset pin rising edge samples strap pin
// - No reset pulse yet: address bit zero
// - Address byte bit zero: 0 write, 1 read
// - START opens, STOP closes, bytes then acknowledge
// - Acknowledge address, index and data bytes
// - Index steps by one per written byte
// - Nonexistent register: not-acknowledge, index kept
// - Index past 255 wraps to zero
// - N data bytes fill N consecutive registers
// - Current-address read uses held index
// - Random read of N registers from index
// - Indexless read starts at previous index
// - Read steps index; master refuses last byte
`timescale 1ns/1ps
`default_nettype none

module i2c_register_access_slave
#(
  parameter logic [7:0] lastRegIndex = i2c_slave_pkg::LAST_REG_DEFAULT
) (
  // System
  input wire logic clock,
  input wire logic sys_rst,
  // Serial link
  input wire logic sclClock,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Device pins
  input wire logic resetPinN,
  input wire logic addr_strap_pin,
  output logic slave_addr_lsb,
  // Register write side
  output logic wrStrobe,
  output logic [7:0] wrIndex,
  output logic [7:0] wrData,
  input wire logic wrAccept,
  // Register read side
  output logic [7:0] rdIndex,
  input wire logic [7:0] rdData
);

  import i2c_slave_pkg::*;

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  // Data is taken on the master's own clock edge; it then stays put
  // for the whole high phase, long enough to be resynchronised.
  logic linkBit;

  always_ff @(posedge sclClock) begin
    linkBit <= sdaIn;
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and line events
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] syncOut;
  logic sclS, sdaS, rstnS, strapS, rxBit;
  logic sclPrev, sdaPrev, rxEvt;
  logic sclFall, startCond, stopCond, evt;

  assign syncIn[SYN_SCL] = sclClock;
  assign syncIn[SYN_SDA] = sdaIn;
  assign syncIn[SYN_RSTN] = resetPinN;
  assign syncIn[SYN_STRAP] = addr_strap_pin;
  assign syncIn[SYN_LBIT] = linkBit;

  sync_bits #(
    .WIDTH(SYNC_W),
    .INIT(SYNC_INIT)
  ) pinSync (
    .clock(clock),
    .sys_rst(sys_rst),
    .dataIn(syncIn),
    .dataOut(syncOut)
  );

  assign sclS = syncOut[SYN_SCL];
  assign sdaS = syncOut[SYN_SDA];
  assign rstnS = syncOut[SYN_RSTN];
  assign strapS = syncOut[SYN_STRAP];
  assign rxBit = syncOut[SYN_LBIT];

  // Rise event is delayed one cycle so the captured bit has surely landed
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      rxEvt <= 1'b0;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
      rxEvt <= sclS && !sclPrev;
    end
  end

  assign sclFall = !sclS && sclPrev;
  assign startCond = sclS && sclPrev && sdaPrev && !sdaS;
  assign stopCond = sclS && sclPrev && !sdaPrev && sdaS;
  assign evt = rxEvt && !startCond && !stopCond;

  // ----------------------------------------------------------------
  // Address strap
  // ----------------------------------------------------------------
  logic rstnPrev;
  logic strapSeen;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rstnPrev <= 1'b1;
      strapSeen <= 1'b0;
      slave_addr_lsb <= LSB_RESET;
    end else begin
      rstnPrev <= rstnS;
      if (rstnS && !rstnPrev) begin
        slave_addr_lsb <= strapS;
        strapSeen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  state_t state;
  logic [2:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] byteIn;
  logic [7:0] txShift;
  logic rwFlag;
  logic ackPending;
  logic lastBit;
  logic addrMatch;
  logic indexOk;
  logic pushNow;
  logic readStep;
  logic idxLoad;
  logic fifoInReady;
  logic fifoOutValid;
  logic [FIFO_W-1:0] fifoOutData;
  logic drainReady;

  assign byteIn = {shiftIn[6:0], rxBit};
  assign lastBit = (bitCnt == BIT_LAST);
  assign addrMatch = (byteIn[7:1] == {SLAVE_ADDR_HIGH, slave_addr_lsb});
  assign indexOk = (rdIndex <= lastRegIndex);
  assign pushNow = evt && (state == ST_WDATA) && lastBit && indexOk && fifoInReady;
  assign readStep = evt && (state == ST_RDATA) && lastBit;
  assign idxLoad = evt && (state == ST_INDEX) && lastBit;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      bitCnt <= BIT_FIRST;
      shiftIn <= INDEX_ZERO;
      txShift <= INDEX_ZERO;
      rwFlag <= 1'b0;
      ackPending <= 1'b0;
    end else if (startCond) begin
      state <= ST_ADDR;
      bitCnt <= BIT_FIRST;
    end else if (stopCond) begin
      state <= ST_IDLE;
    end else if (evt) begin
      case (state)
        ST_ADDR: begin
          shiftIn <= byteIn;
          bitCnt <= bitCnt + 1'b1;
          if (lastBit) begin
            rwFlag <= byteIn[0];
            ackPending <= addrMatch;
            state <= addrMatch ? ST_ADDR_ACK : ST_IGNORE;
          end
        end
        ST_INDEX: begin
          shiftIn <= byteIn;
          bitCnt <= bitCnt + 1'b1;
          if (lastBit) begin
            ackPending <= 1'b1;
            state <= ST_INDEX_ACK;
          end
        end
        ST_WDATA: begin
          shiftIn <= byteIn;
          bitCnt <= bitCnt + 1'b1;
          if (lastBit) begin
            ackPending <= pushNow;
            state <= ST_WDATA_ACK;
          end
        end
        ST_ADDR_ACK: begin
          bitCnt <= BIT_FIRST;
          if (rwFlag == DIR_READ) begin
            txShift <= rdData;
            state <= ST_RDATA;
          end else begin
            state <= ST_INDEX;
          end
        end
        ST_INDEX_ACK, ST_WDATA_ACK: begin
          bitCnt <= BIT_FIRST;
          state <= ST_WDATA;
        end
        ST_RDATA: begin
          txShift <= {txShift[6:0], 1'b0};
          bitCnt <= bitCnt + 1'b1;
          if (lastBit) begin
            state <= ST_RDATA_ACK;
          end
        end
        ST_RDATA_ACK: begin
          bitCnt <= BIT_FIRST;
          // A refused byte ends the read; wait for STOP
          if (rxBit) begin
            state <= ST_IGNORE;
          end else begin
            txShift <= rdData;
            state <= ST_RDATA;
          end
        end
        ST_IDLE, ST_IGNORE: state <= state;
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register index
  // ----------------------------------------------------------------
  // Index survives STOP so an indexless read continues where the last
  // transfer left it; 8-bit arithmetic gives the wrap for free.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdIndex <= INDEX_ZERO;
    end else if (idxLoad) begin
      rdIndex <= byteIn;
    end else if (pushNow || readStep) begin
      rdIndex <= rdIndex + INDEX_STEP;
    end
  end

  // ----------------------------------------------------------------
  // Data line drive
  // ----------------------------------------------------------------
  // Changes only after SCL falls or at START/STOP (cleared), so SDA is steady while SCL is high in a byte
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
    end else if (startCond || stopCond) begin
      sdaOe <= 1'b0;
    end else if (sclFall) begin
      case (state)
        ST_ADDR_ACK, ST_INDEX_ACK, ST_WDATA_ACK: begin
          sdaOe <= ackPending;
        end
        ST_RDATA: begin
          sdaOe <= !txShift[7];
        end
        default: begin
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write buffer and drain
  // ----------------------------------------------------------------
  // A full buffer refuses the byte rather than stretching the clock
  fifo_buffer #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) writeBuffer (
    .clock(clock),
    .sys_rst(sys_rst),
    .inValid(pushNow),
    .inData({rdIndex, byteIn}),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(drainReady)
  );

  assign drainReady = !wrStrobe || wrAccept;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wrStrobe <= 1'b0;
      wrIndex <= INDEX_ZERO;
      wrData <= INDEX_ZERO;
    end else if (fifoOutValid && drainReady) begin
      wrStrobe <= 1'b1;
      {wrIndex, wrData} <= fifoOutData;
    end else if (wrAccept) begin
      wrStrobe <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence seqAddrEnd;
    evt && (state == ST_ADDR) && (bitCnt == BIT_LAST);
  endsequence

  sequence seqWdataEnd;
    evt && (state == ST_WDATA) && (bitCnt == BIT_LAST);
  endsequence

  chk_addr_accept: assert property (
    seqAddrEnd ##0 addrMatch |=> (state == ST_ADDR_ACK) && ackPending)
    else $error("own address not accepted");
  chk_addr_reject: assert property (
    seqAddrEnd ##0 !addrMatch |=> (state == ST_IGNORE) ##1 !sdaOe)
    else $error("foreign address not ignored");
  chk_strap_sample: assert property (
    (rstnS && !rstnPrev) |=> (slave_addr_lsb == $past(strapS)))
    else $error("strap not taken at reset pin rise");
  chk_lsb_default: assert property (!strapSeen |-> !slave_addr_lsb)
    else $error("address bit set without reset pulse");
  chk_dir_latch: assert property (seqAddrEnd |=> rwFlag == $past(rxBit))
    else $error("direction bit not latched");
  chk_start_frame: assert property (
    startCond |=> (state == ST_ADDR) && (bitCnt == BIT_FIRST) && !sdaOe)
    else $error("START did not restart framing");
  chk_index_ack: assert property (
    (sclFall && (state == ST_INDEX_ACK) && !startCond && !stopCond) |=> sdaOe)
    else $error("index byte not acknowledged");
  chk_write_step: assert property (
    pushNow |=> (rdIndex == $past(rdIndex) + INDEX_STEP) && (state == ST_WDATA_ACK))
    else $error("index not stepped after write");
  chk_bad_index: assert property (
    seqWdataEnd ##0 !indexOk |=> $stable(rdIndex) && !ackPending)
    else $error("nonexistent register acknowledged");
  chk_index_wrap: assert property (
    (pushNow || readStep) && (rdIndex == INDEX_MAX) |=> (rdIndex == INDEX_ZERO))
    else $error("index did not wrap to zero");
  chk_read_load: assert property (
    (evt && (state == ST_ADDR_ACK) && rwFlag) |=> (txShift == $past(rdData)))
    else $error("read byte not loaded from index");
  chk_read_step: assert property (
    readStep |=> (rdIndex == $past(rdIndex) + INDEX_STEP) ##1 (state == ST_RDATA_ACK))
    else $error("index not stepped after read");

endmodule : i2c_register_access_slave

`default_nettype wire

// ### tb/i2c_host_model.sv
// Bit-banged two-wire bus master driving the serial clock and pulling the data line.
// Assumes an open-drain data line with a pull-up, resolved by the bench.
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model #(
  parameter int HALF_NS = 240
) (
  // Bus lines
  output var logic sclClock,
  output var logic sdaPull,
  input wire logic sdaLine
);
  // Clock stands high and the line is released between frames
  initial begin
    sclClock = 1'b1;
    sdaPull = 1'b0;
  end

  // ----------------------------------------
  // Bit level
  // ----------------------------------------
  // Data moves a quarter phase after the fall, never with it
  task automatic put_bit(input logic b);
    #(HALF_NS / 4);
    sdaPull = ~b;
    #(HALF_NS);
    sclClock = 1'b1;
    #(HALF_NS);
    sclClock = 1'b0;
  endtask : put_bit

  task automatic get_bit(output logic b);
    #(HALF_NS / 4);
    sdaPull = 1'b0;
    #(HALF_NS);
    sclClock = 1'b1;
    #(HALF_NS / 2);
    b = sdaLine;
    #(HALF_NS / 2);
    sclClock = 1'b0;
  endtask : get_bit

  // ----------------------------------------
  // Framing
  // ----------------------------------------
  // Also serves as repeated START from a low clock
  task automatic start_cond();
    #(HALF_NS / 4);
    sdaPull = 1'b0;
    #(HALF_NS);
    sclClock = 1'b1;
    #(HALF_NS);
    sdaPull = 1'b1;
    #(HALF_NS);
    sclClock = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #(HALF_NS / 4);
    sdaPull = 1'b1;
    #(HALF_NS);
    sclClock = 1'b1;
    #(HALF_NS);
    sdaPull = 1'b0;
    #(HALF_NS);
  endtask : stop_cond

  // Eight bits most significant first, then the slave's acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_bit(x);
    ack = ~x;
  endtask : send_byte

  // Master refuses only the last byte of a read
  task automatic recv_byte(input logic lastByte, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(lastByte);
  endtask : recv_byte
endmodule : i2c_host_model

`default_nettype wire

// ### tb/i2c_register_access_slave_bench.sv
// Self-checking bench for the two-wire register access slave.
// Assumes the host model above and a 256-entry register file modelled here.
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp) begin \
  numChecks++; \
  if ((got) !== (exp)) begin \
    failCount++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module i2c_register_access_slave_bench;
  import i2c_slave_pkg::*;
  localparam int TIMEOUT = 40000;
  localparam logic [6:0] BASE = {SLAVE_ADDR_HIGH, 1'b0};

  logic clock, sys_rst, sclClock, sdaPull, sdaOut, sdaOe, sdaLine;
  logic resetPinN, addrStrap, lsb, wrStrobe, wrAccept, ack;
  logic [7:0] wrIndex, wrData, rdIndex, rdData, d;
  logic [7:0] regs [0:255];
  int failCount = 0;
  int numChecks = 0;
  int cycles = 0;

  // ----------------------------------------
  // Clock, wire and register file
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  assign sdaLine = !(sdaPull || (sdaOe === 1'b1 && sdaOut === 1'b0));
  assign rdData = regs[rdIndex];

  function automatic logic [7:0] init_val(input int i);
    return 8'(i) ^ 8'h5a;
  endfunction : init_val

  always @(posedge clock) begin
    if (wrStrobe === 1'b1 && wrAccept) begin
      regs[wrIndex] <= wrData;
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      failCount++;
      report_and_stop();
    end
  end

  i2c_host_model u_host (.sclClock(sclClock), .sdaPull(sdaPull), .sdaLine(sdaLine));

  i2c_register_access_slave u_dut (
    .clock(clock), .sys_rst(sys_rst), .sclClock(sclClock), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .resetPinN(resetPinN), .addr_strap_pin(addrStrap),
    .slave_addr_lsb(lsb), .wrStrobe(wrStrobe), .wrIndex(wrIndex), .wrData(wrData),
    .wrAccept(wrAccept), .rdIndex(rdIndex), .rdData(rdData)
  );

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic open_txn(input logic [6:0] a, input logic rw);
    u_host.start_cond();
    u_host.send_byte({a, rw}, ack);
  endtask : open_txn

  task automatic test_default_lsb();
    `CHECK(lsb, 1'b0)
    open_txn(BASE | 7'h01, 1'b0);
    `CHECK(ack, 1'b0)
    u_host.stop_cond();
    open_txn(BASE, 1'b0);
    `CHECK(ack, 1'b1)
    u_host.stop_cond();
  endtask : test_default_lsb

  task automatic test_single_write();
    open_txn(BASE, 1'b0);
    `CHECK(ack, 1'b1)
    u_host.send_byte(8'h10, ack);
    `CHECK(ack, 1'b1)
    u_host.send_byte(8'ha5, ack);
    `CHECK(ack, 1'b1)
    u_host.stop_cond();
    `CHECK(regs[8'h10], 8'ha5)
    `CHECK(regs[8'h11], init_val(8'h11))
  endtask : test_single_write

  // Register file stalls; output stage plus eight buffer entries hold nine
  task automatic test_buffer_full();
    @(posedge clock);
    wrAccept <= 1'b0;
    open_txn(BASE, 1'b0);
    u_host.send_byte(8'h20, ack);
    for (int i = 0; i < 10; i++) begin
      u_host.send_byte(8'hc0 + 8'(i), ack);
      `CHECK(ack, logic'(i < 9))
    end
    u_host.stop_cond();
    `CHECK(wrIndex, 8'h20)
    `CHECK(rdIndex, 8'h29)
    @(posedge clock);
    wrAccept <= 1'b1;
    for (int n = 0; n < 50 && wrStrobe !== 1'b0; n++) begin
      @(posedge clock);
    end
    @(posedge clock);
    for (int i = 0; i < 9; i++) begin
      `CHECK(regs[8'h20 + 8'(i)], 8'hc0 + 8'(i))
    end
    `CHECK(regs[8'h29], init_val(8'h29))
  endtask : test_buffer_full

  // Refused write keeps the index; a bare read then starts there
  task automatic test_nonexistent();
    open_txn(BASE, 1'b0);
    u_host.send_byte(8'h80, ack);
    `CHECK(ack, 1'b1)
    u_host.send_byte(8'h33, ack);
    `CHECK(ack, 1'b0)
    u_host.stop_cond();
    open_txn(BASE, 1'b1);
    `CHECK(ack, 1'b1)
    u_host.recv_byte(1'b1, d);
    u_host.stop_cond();
    `CHECK(d, init_val(8'h80))
  endtask : test_nonexistent

  task automatic test_read_wrap();
    open_txn(BASE, 1'b0);
    u_host.send_byte(8'hfe, ack);
    open_txn(BASE, 1'b1);
    `CHECK(ack, 1'b1)
    for (int i = 0; i < 3; i++) begin
      u_host.recv_byte(logic'(i == 2), d);
      `CHECK(d, init_val((8'hfe + i) % 256))
    end
    u_host.stop_cond();
    `CHECK(rdIndex, 8'h01)
    open_txn(BASE, 1'b1);
    u_host.recv_byte(1'b1, d);
    u_host.stop_cond();
    `CHECK(d, init_val(8'h01))
  endtask : test_read_wrap

  task automatic test_strap(input logic level);
    @(posedge clock);
    addrStrap <= level;
    resetPinN <= 1'b0;
    repeat (10) @(posedge clock);
    resetPinN <= 1'b1;
    repeat (10) @(posedge clock);
    `CHECK(lsb, level)
    open_txn(BASE | 7'(level), 1'b0);
    `CHECK(ack, 1'b1)
    u_host.stop_cond();
    open_txn(BASE | {6'h00, ~level}, 1'b0);
    `CHECK(ack, 1'b0)
    u_host.stop_cond();
  endtask : test_strap

  task automatic report_and_stop();
    if (failCount == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = init_val(i);
    end
    sys_rst = 1'b1;
    resetPinN = 1'b1;
    addrStrap = 1'b1;
    wrAccept = 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clock);
    test_default_lsb();
    test_single_write();
    test_buffer_full();
    test_nonexistent();
    test_read_wrap();
    test_strap(1'b1);
    test_strap(1'b0);
    report_and_stop();
  end
endmodule : i2c_register_access_slave_bench

`default_nettype wire
